// >>> wfif_filter.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module wfif_filter (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        softReset,
    input  wire logic        restart,
    input  wire logic        stopMode,
    input  wire logic        wakeEvent,
    input  wire logic        frameValid,
    input  wire logic [28:0] frameIdent,
    input  wire logic        frameExtended,
    output logic      [5:0]  samplePointFrac,
    output logic             configValidFlag,
    output logic             wakeFrameSeen,
    output logic             wakeFrameMatch
);

    typedef struct packed {
        logic [5:0]  samplePoint;
        logic [28:0] identBits;
        logic        identExt;
        logic        identRemote;
        logic [28:0] compareSel;
        logic        ready;
        logic        slvErr;
        logic [31:0] rdata;
    } wfif_state_t;

    wfif_state_t st_q;
    wfif_state_t st_d;

    logic [5:0] regIdx;
    logic       setupPhase;
    logic       accessDone;
    logic       wrStrobe;
    logic       cfgWrite;
    logic       ctrlWrite;
    logic       setValid;
    logic       clearValid;
    logic       validFlag;
    logic       matchDone;
    logic       matchHit;

    // True for aligned addresses that land on a register
    function automatic logic isMapped(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        isMapped = (addr[1:0] == 2'b00) &&
                   ((idx == wfif_pkg::IDX_VALID_CTRL) ||
                    ((idx >= wfif_pkg::IDX_SAMPLE) &&
                     (idx <= wfif_pkg::IDX_CMPSEL_LOW)));
    endfunction

    // True for the identifier, mask and timing registers
    function automatic logic isConfigReg(input logic [5:0] idx);
        isConfigReg = (idx >= wfif_pkg::IDX_SAMPLE) &&
                      (idx <= wfif_pkg::IDX_CMPSEL_LOW);
    endfunction

    // Five-bit low field of a write word, shared by ident and mask
    function automatic logic [4:0] lowField(input logic [31:0] wd);
        lowField = wd[wfif_pkg::LOW_FIELD_MSB:wfif_pkg::LOW_FIELD_LSB];
    endfunction

    // Read view of one register; unused bits are returned as zero
    function automatic logic [7:0] readReg(input logic [5:0] idx,
                                           input wfif_state_t s,
                                           input logic vflag);
        readReg = 8'h00;
        unique case (idx)
            wfif_pkg::IDX_VALID_CTRL: readReg[wfif_pkg::VALID_BIT] = vflag;
            wfif_pkg::IDX_SAMPLE:     readReg = {2'b00, s.samplePoint};
            wfif_pkg::IDX_IDENT3:     readReg = s.identBits[28:21];
            wfif_pkg::IDX_IDENT2:     readReg = s.identBits[20:13];
            wfif_pkg::IDX_IDENT1:     readReg = s.identBits[12:5];
            wfif_pkg::IDX_IDENT_LOW:
                readReg = {1'b0, s.identBits[4:0], s.identRemote,
                           s.identExt};
            wfif_pkg::IDX_CMPSEL3:    readReg = s.compareSel[28:21];
            wfif_pkg::IDX_CMPSEL2:    readReg = s.compareSel[20:13];
            wfif_pkg::IDX_CMPSEL1:    readReg = s.compareSel[12:5];
            wfif_pkg::IDX_CMPSEL_LOW:
                readReg = {1'b0, s.compareSel[4:0], 2'b00};
            default:                  readReg = 8'h00;
        endcase
    endfunction

    // Bus phase decode
    assign regIdx     = paddr[7:2];
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && st_q.ready;
    assign wrStrobe   = accessDone && pwrite && pstrb[0] && isMapped(paddr);

    // Valid flag steering; a write of the flag itself in stop mode
    // also counts as a configuration change
    assign cfgWrite   = wrStrobe && isConfigReg(regIdx);
    assign ctrlWrite  = wrStrobe && (regIdx == wfif_pkg::IDX_VALID_CTRL);
    assign setValid   = ctrlWrite && pwdata[wfif_pkg::VALID_BIT] && !stopMode;
    assign clearValid = cfgWrite
                        || (ctrlWrite && stopMode)
                        || (ctrlWrite && !pwdata[wfif_pkg::VALID_BIT])
                        || wakeEvent;

    // Next state: bus answer, register writes, soft reset
    always_comb begin
        st_d        = st_q;
        st_d.ready  = 1'b0;
        st_d.slvErr = 1'b0;
        // Answer is staged in setup so that every bus output is a flop
        if (setupPhase) begin
            st_d.ready  = 1'b1;
            st_d.slvErr = !isMapped(paddr);
            st_d.rdata  = wfif_pkg::RDATA_RST;
            if (!pwrite && isMapped(paddr)) begin
                st_d.rdata = {24'h000000, readReg(regIdx, st_q, validFlag)};
            end
        end else if (psel && penable && !st_q.ready) begin
            st_d.ready = 1'b1;     // Late access without setup still ends
        end else if (accessDone) begin
            st_d.ready = 1'b0;
        end
        // Register writes land on the access edge only
        if (wrStrobe) begin
            unique case (regIdx)
                wfif_pkg::IDX_SAMPLE:
                    st_d.samplePoint = pwdata[5:0];
                wfif_pkg::IDX_IDENT3:
                    st_d.identBits[28:21] = pwdata[7:0];
                wfif_pkg::IDX_IDENT2:
                    st_d.identBits[20:13] = pwdata[7:0];
                wfif_pkg::IDX_IDENT1:
                    st_d.identBits[12:5] = pwdata[7:0];
                wfif_pkg::IDX_IDENT_LOW: begin
                    st_d.identBits[4:0] = lowField(pwdata);
                    st_d.identRemote = pwdata[wfif_pkg::REMOTE_BIT];
                    st_d.identExt    = pwdata[wfif_pkg::EXT_BIT];
                end
                wfif_pkg::IDX_CMPSEL3:
                    st_d.compareSel[28:21] = pwdata[7:0];
                wfif_pkg::IDX_CMPSEL2:
                    st_d.compareSel[20:13] = pwdata[7:0];
                wfif_pkg::IDX_CMPSEL1:
                    st_d.compareSel[12:5] = pwdata[7:0];
                wfif_pkg::IDX_CMPSEL_LOW:
                    st_d.compareSel[4:0] = lowField(pwdata);
                default: begin
                end
            endcase
        end
        // Soft reset reloads defaults; restart deliberately leaves the
        // stored frame pattern alone, the unused mask bits are not held
        if (softReset) begin
            st_d.samplePoint = wfif_pkg::SAMPLE_RST;
            st_d.identBits   = wfif_pkg::IDENT_RST;
            st_d.identExt    = 1'b0;
            st_d.identRemote = 1'b0;
            st_d.compareSel  = wfif_pkg::CMPSEL_RST;
        end else if (restart) begin
            st_d.ready  = 1'b0;    // Bus answer dropped, contents kept
            st_d.slvErr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.samplePoint <= wfif_pkg::SAMPLE_RST;
            st_q.identBits   <= wfif_pkg::IDENT_RST;
            st_q.identExt    <= 1'b0;
            st_q.identRemote <= 1'b0;
            st_q.compareSel  <= wfif_pkg::CMPSEL_RST;
            st_q.ready       <= 1'b0;
            st_q.slvErr      <= 1'b0;
            st_q.rdata       <= wfif_pkg::RDATA_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Configuration valid flag
    wfif_valid_flag u_valid (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .softReset   (softReset),
        .setValid    (setValid),
        .clearValid  (clearValid),
        .validFlag_q (validFlag)
    );

    // Frame identifier comparison, one cycle after the frame strobe
    wfif_id_match u_match (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .frameValid    (frameValid),
        .frameIdent    (frameIdent),
        .frameExtended (frameExtended),
        .identBits     (st_q.identBits),
        .identExt      (st_q.identExt),
        .compareSel    (st_q.compareSel),
        .matchDone_q   (matchDone),
        .matchHit_q    (matchHit)
    );

    // Outputs come straight from flops
    assign prdata          = st_q.rdata;
    assign pready          = st_q.ready;
    assign pslverr         = st_q.slvErr;
    assign samplePointFrac = st_q.samplePoint;
    assign configValidFlag = validFlag;
    assign wakeFrameSeen   = matchDone;
    assign wakeFrameMatch  = matchHit;

endmodule

// >>> wfif_filter_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the filter registers and frame path
module wfif_filter_assertions (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        softReset,
    input wire logic        restart,
    input wire logic        stopMode,
    input wire logic        frameValid,
    input wire logic [5:0]  samplePointFrac,
    input wire logic        configValidFlag,
    input wire logic        wakeFrameSeen
);
    logic wrDone;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Accepted low-byte write completing at this edge
    assign wrDone = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

    property p_frac_rst;
        softReset |=> samplePointFrac == wfif_pkg::SAMPLE_RST;
    endproperty
    a_frac_rst: assert property (p_frac_rst) else $error("frac default");
    property p_frac_wr;
        wrDone && paddr == 8'h88 && !softReset
            |=> samplePointFrac == $past(pwdata[5:0]);
    endproperty
    a_frac_wr: assert property (p_frac_wr) else $error("frac write");
    property p_rsvd_sp;
        pready && !pwrite && paddr == 8'h88 |-> prdata[31:6] == 26'h0;
    endproperty
    a_rsvd_sp: assert property (p_rsvd_sp) else $error("frac rsvd");
    property p_rsvd_lo;
        pready && !pwrite && paddr inside {8'h98, 8'hA8} |-> prdata[31:7] == 25'h0
            && (paddr != 8'hA8 || prdata[1:0] == 2'h0);
    endproperty
    a_rsvd_lo: assert property (p_rsvd_lo) else $error("low rsvd");
    property p_cfg_clr;
        wrDone && paddr[7:2] inside {[6'h22:6'h2A]} |=> !configValidFlag;
    endproperty
    a_cfg_clr: assert property (p_cfg_clr) else $error("flag kept");
    property p_stop_clr;
        stopMode && wrDone && paddr == 8'h80 |=> !configValidFlag;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop flag");
    property p_seen;
        frameValid |=> wakeFrameSeen;
    endproperty
    a_seen: assert property (p_seen) else $error("frame missed");
    property p_restart;
        restart && !softReset && !psel |=> $stable(samplePointFrac);
    endproperty
    a_restart: assert property (p_restart) else $error("restart lost");
endmodule

// >>> wfif_filter_tb_top.sv
`timescale 1ns/1ps
module wfif_filter_tb_top;
    logic        core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, softReset = 1'b0;
    logic        restart = 1'b0, stopMode = 1'b0, wakeEvent = 1'b0;
    logic        sendReq = 1'b0, sendExt = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [28:0] sendIdent = 29'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, frameValid, frameExtended;
    logic        configValidFlag, wakeFrameSeen, wakeFrameMatch;
    logic [28:0] frameIdent;
    logic [5:0]  samplePointFrac;
    logic [7:0]  cfgB[8];
    logic [7:0]  wm[9] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h7F,
                           8'hFF, 8'hFF, 8'hFF, 8'h7C};
    int          miscompares = 0;
    int          comparisons = 0;

    wfif_filter u_dut (.*);
    wfif_frame_src u_src (.*);
    // Free-running 100 MHz clock
    always #5 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask

    // One transfer; bounded wait for pready, returns one edge later
    // so that callers change inputs on a rising edge only
    task automatic apb(logic w, logic [7:0] a, logic [7:0] d,
                       output logic [31:0] rd, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            miscompares++;
            print_verdict();
        end
        @(posedge core_clk);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(logic [7:0] a, logic [7:0] x);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 8'h00, rd, e);
        chk($sformatf("reg %h", a), {24'h0, x}, rd);
    endtask

    task automatic defaults();
        for (int i = 0; i < 9; i++) begin
            rdchk(8'h88 + 8'(4 * i),
                  i == 0 ? {2'b00, wfif_pkg::SAMPLE_RST} : 8'h00);
        end
        chk("flag", 32'h0, {31'h0, configValidFlag});
    endtask

    task automatic cfg(logic [28:0] c, logic ce, logic [28:0] s);
        cfgB = '{c[28:21], c[20:13], c[12:5], {1'b0, c[4:0], 1'b0, ce},
                 s[28:21], s[20:13], s[12:5], {1'b0, s[4:0], 2'b00}};
        for (int i = 0; i < 8; i++) begin
            wr(8'h8C + 8'(4 * i), cfgB[i]);
        end
    endtask

    task automatic frame(logic [28:0] f, logic fe, logic x);
        int n;
        @(posedge core_clk);
        sendReq <= 1'b1;
        sendIdent <= f;
        sendExt <= fe;
        @(posedge core_clk);
        sendReq <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wakeFrameSeen !== 1'b1 && n < 8);
        if (n >= 8) begin
            miscompares++;
            print_verdict();
        end
        chk("match", {31'h0, x}, {31'h0, wakeFrameMatch});
    endtask

    function automatic logic hit(logic [28:0] c, s, f, logic ce, fe);
        return (((c ^ f) & s) == 29'h0) && (ce == fe);
    endfunction

    initial begin
        logic [28:0] c, s, f;
        logic        ce, fe, e;
        logic [31:0] rd;
        rd = $urandom(29);
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        defaults();
        // All-ones writes: reserved bits must read back zero
        for (int i = 0; i < 9; i++) begin
            wr(8'h88 + 8'(4 * i), 8'hFF);
            rdchk(8'h88 + 8'(4 * i), wm[i]);
        end
        chk("frac", 32'h3F, {26'h0, samplePointFrac});
        wr(8'h98, 8'h03);
        rdchk(8'h98, 8'h03);
        // Unmapped and misaligned accesses are refused
        apb(1'b0, 8'h84, 8'h00, rd, e);
        chk("err", 32'h1, {31'h0, e});
        apb(1'b1, 8'h89, 8'h00, rd, e);
        chk("err", 32'h1, {31'h0, e});
        rdchk(8'h88, 8'h3F);
        // Write with the low byte lane off must be ignored
        pstrb <= 4'hE;
        wr(8'h88, 8'h15);
        pstrb <= 4'hF;
        rdchk(8'h88, 8'h3F);
        wr(8'h80, 8'h01);
        chk("flag", 32'h1, {31'h0, configValidFlag});
        wr(8'h8C, 8'hFF);
        chk("flag", 32'h0, {31'h0, configValidFlag});
        wr(8'h80, 8'h01);
        stopMode <= 1'b1;
        wr(8'h80, 8'h01);
        chk("flag", 32'h0, {31'h0, configValidFlag});
        stopMode <= 1'b0;
        // A wake event clears a set flag
        wr(8'h80, 8'h01);
        chk("flag", 32'h1, {31'h0, configValidFlag});
        wakeEvent <= 1'b1;
        @(posedge core_clk);
        wakeEvent <= 1'b0;
        @(posedge core_clk);
        chk("flag", 32'h0, {31'h0, configValidFlag});
        // Random filters; first two compare every used ident bit and none
        for (int k = 0; k < 24; k++) begin
            c = 29'($urandom);
            ce = 1'($urandom);
            s = k == 0 ? 29'h1FFFFFFF : k == 1 ? 29'h0 : 29'($urandom);
            if (!ce) begin
                s[17:0] = 18'h0;
                c[17:0] = 18'h0;
            end
            cfg(c, ce, s);
            f = k % 2 ? c ^ (29'h1 << ($urandom % 29)) : c;
            fe = k % 5 == 2 ? !ce : ce;
            frame(f, fe, hit(c, s, f, ce, fe));
        end
        restart <= 1'b1;
        @(posedge core_clk);
        restart <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdchk(8'h8C + 8'(4 * i), cfgB[i]);
        end
        wr(8'h80, 8'h01);
        softReset <= 1'b1;
        @(posedge core_clk);
        softReset <= 1'b0;
        defaults();
        print_verdict();
    end
endmodule

bind wfif_filter wfif_filter_assertions u_chk (.*);

// >>> wfif_frame_src.sv
`timescale 1ns/1ps
// Bus node model: one received frame per request
module wfif_frame_src (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        sendReq,
    input  wire logic [28:0] sendIdent,
    input  wire logic        sendExt,
    output logic             frameValid,
    output logic      [28:0] frameIdent,
    output logic             frameExtended
);
    // Fields toggle between frames, so stale values never look valid
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frameValid <= 1'b0;
            frameIdent <= 29'h0;
            frameExtended <= 1'b0;
        end else if (sendReq) begin
            frameValid <= 1'b1;
            frameIdent <= sendExt ? sendIdent
                : {sendIdent[28:18], ~sendIdent[17:0]};
            frameExtended <= sendExt;
        end else begin
            frameValid <= 1'b0;
            frameIdent <= ~frameIdent;
            frameExtended <= ~frameExtended;
        end
    end
endmodule

// >>> wfif_id_match.sv
`timescale 1ns/1ps
module wfif_id_match (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        frameValid,
    input  wire logic [28:0] frameIdent,
    input  wire logic        frameExtended,
    input  wire logic [28:0] identBits,
    input  wire logic        identExt,
    input  wire logic [28:0] compareSel,
    output logic             matchDone_q,
    output logic             matchHit_q
);

    typedef struct packed {
        logic done;
        logic hit;
    } wfif_match_t;

    wfif_match_t st_q;
    wfif_match_t st_d;

    // Selected bits must agree and the length flag must agree
    always_comb begin
        st_d      = st_q;
        st_d.done = frameValid;
        if (frameValid) begin
            st_d.hit = (((frameIdent ^ identBits) & compareSel) == '0)
                       && (frameExtended == identExt);
        end
    end

    // Result held until the next frame
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign matchDone_q = st_q.done;
    assign matchHit_q  = st_q.hit;

endmodule

// >>> wfif_pkg.sv
package wfif_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_VALID_CTRL  = 6'h20;
    localparam logic [5:0] IDX_SAMPLE      = 6'h22;
    localparam logic [5:0] IDX_IDENT3      = 6'h23;
    localparam logic [5:0] IDX_IDENT2      = 6'h24;
    localparam logic [5:0] IDX_IDENT1      = 6'h25;
    localparam logic [5:0] IDX_IDENT_LOW   = 6'h26;
    localparam logic [5:0] IDX_CMPSEL3     = 6'h27;
    localparam logic [5:0] IDX_CMPSEL2     = 6'h28;
    localparam logic [5:0] IDX_CMPSEL1     = 6'h29;
    localparam logic [5:0] IDX_CMPSEL_LOW  = 6'h2A;

    // Field positions
    localparam int EXT_BIT       = 0;
    localparam int REMOTE_BIT    = 1;
    localparam int LOW_FIELD_LSB = 2;
    localparam int LOW_FIELD_MSB = 6;
    localparam int VALID_BIT     = 0;

    // Reset values
    localparam logic [5:0]  SAMPLE_RST   = 6'h33;
    localparam logic [28:0] IDENT_RST    = 29'h0000000;
    localparam logic [28:0] CMPSEL_RST   = 29'h0000000;
    localparam logic        FLAG_RST     = 1'b0;
    localparam logic [31:0] RDATA_RST    = 32'h00000000;

endpackage

// >>> wfif_valid_flag.sv
`timescale 1ns/1ps
module wfif_valid_flag (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic softReset,
    input  wire logic setValid,
    input  wire logic clearValid,
    output logic      validFlag_q
);

    typedef struct packed {
        logic valid;
    } wfif_flag_t;

    wfif_flag_t flag_q;
    wfif_flag_t flag_d;

    // Hardware clear beats a software set: a change of data must
    // never leave a stale configuration marked as valid
    always_comb begin
        flag_d = flag_q;
        if (softReset || clearValid) begin
            flag_d.valid = 1'b0;
        end else if (setValid) begin
            flag_d.valid = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q.valid <= wfif_pkg::FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign validFlag_q = flag_q.valid;

endmodule
